// *** hdl/fhr_defines.svh ***
`ifndef FHR_DEFINES_SVH
`define FHR_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define FHR_IDX_TAPE 10'h3F3
`define FHR_IDX_RATE 10'h3F4
`define FHR_IDX_DATA 10'h3F5
`define FHR_IDX_INPUT 10'h3F7
`define FHR_IDX_DOC 10'h000
`define FHR_IDX_IFM 10'h001
`define FHR_IDX_DTC 10'h002
`define FHR_IDX_MISC 10'h003

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define FHR_RSEL_RST_BIT 7
`define FHR_RSEL_PWR_BIT 6
`define FHR_RATE_RESET 2'h2
`define FHR_PRECOMP_RESET 3'h0
`define FHR_PRECOMP_DEFAULT 3'h7
`define FHR_FILL_BYTE 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define FHR_CLK_NS 25
`define FHR_SWRST_NS 100
`define FHR_SWRST_CYC ((`FHR_SWRST_NS + `FHR_CLK_NS - 1) / `FHR_CLK_NS)
// Precompensation figures in units of 10 ps
`define FHR_PRE_STEP_LO 16'd4167
`define FHR_PRE_STEP_HI 16'd2080
`define FHR_PRE_DEF_LO 16'd12500

// ----------------------------------------
// Data rates in Kbps
// ----------------------------------------
`define FHR_KBPS_2M 12'd2000
`define FHR_KBPS_1M 12'd1000
`define FHR_KBPS_500 12'd500
`define FHR_KBPS_300 12'd300
`define FHR_KBPS_250 12'd250

`endif

// *** hdl/fhr_pkg.sv ***
`default_nettype none

package fhr_pkg;

    // ----------------------------------------
    // Register interface modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        FHR_MODE_FIRST = 2'b00,
        FHR_MODE_SECOND = 2'b01,
        FHR_MODE_THIRD = 2'b10,
        FHR_MODE_SPARE = 2'b11
    } fhr_mode_t;

    // Status delivered by the controller core
    typedef struct packed {
        logic host_transfer_allowed;
        logic transfer_way;
        logic cmd_busy;
        logic drive_seeking;
        logic fifo_cfg_set;
        logic exec_phase;
        logic xfer_error;
        logic disk_write;
        logic mfm;
        logic [7:0] rd_byte;
    } fhr_core_stat_t;

    // Commands toward the controller core
    typedef struct packed {
        logic core_reset;
        logic low_power;
        logic fifo_active;
        logic fifo_flush;
        logic cmd_abort;
        logic zero_fill;
        logic data_wr;
        logic data_rd;
        logic [7:0] data_wr_byte;
        logic transfer_engine_enable;
        logic [1:0] drive_select;
    } fhr_core_ctl_t;

    // Drive cable side outputs
    typedef struct packed {
        logic density_output;
        logic [1:0] drive_density_pins;
        logic [2:0] precomp_code;
        logic [15:0] precomp_delay;
        logic [11:0] rate_kbps;
    } fhr_drive_out_t;

    // Whole state of the register slice
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic dsk_s1;
        logic dsk_s2;
        logic [1:0] rate;
        logic [2:0] precomp;
        logic no_precomp_flag;
        logic [2:0] swrst_cnt;
        logic [1:0] drv_ctl_sel;
        logic drv_ctl_run;
        logic drv_ctl_engine;
        logic [1:0] tape_unit_select;
        fhr_mode_t iface_mode;
        logic [7:0] dtype_cfg;
        logic [1:0] drive_rate_setting;
        logic [1:0] drive_type_setting;
        logic tape_enhanced;
        logic force_en;
        logic force_val;
        logic fifo_en;
        logic exec_seen;
        fhr_core_ctl_t ctl;
        fhr_drive_out_t drv;
    } fhr_state_t;

endpackage : fhr_pkg

`default_nettype wire

// *** hdl/fhr_regs.sv ***
// How it works
// (R01) Normal mode: tape register keeps two select bits, bits 2-7 read zero.
// (R02) Enhanced mode: tape bits 5:4 show drive-type pair picked by drive select.
// (R03) Rate register write-only, hardware reset loads 02h, software reset keeps it.
// (R04) Active data rate is the latest rate write of either register.
// (R05) Rate bits 2-4 pick precompensation delay; steps 41.67 ns or 20.8 ns.
// (R06) Bit 6 enters low power; data port, status read or soft reset exit it.
// (R07) Bit 7 resets the controller like the drive control reset, self clearing.
// (R08) Rate codes 11/00/10/01 map to 1M/500K/250K/300-500-2M; FM halves; density high for 11,00.
// (R09) Drive density pins are chosen from rate bits and density by drive type.
// (R10) Main status readable any time, valid straight after a data transfer.
// (R11) Status bit 0 shows seeking; bits 1-3 and 5 read zero.
// (R12) Status bit 4 shows command busy, as reported by the core.
// (R13) Status bit 7 allows transfer, bit 6 gives direction.
// (R14) Host reads main status before each non-DMA data byte.
// (R15) Any reset disables the FIFO until a configure command enables it.
// (R16) FIFO bypassed during command phase, flushed on entering execution.
// (R17) Overrun/underrun aborts the command; disk writes finish with zero fill.
// (R18) Host services a threshold request within threshold x 8 bit times less 1.5 us.
// (R19) First mode input register: bits 0-6 zero, bit 7 media change or forced value.
// (R20) Second mode: low density bit, rate bits, ones in 3-6, media change.
// (R21) Third mode: rate bits, no-precomp echo, engine enable echo, zeros in 4-6.
// (R22) Density output high after hardware reset, untouched by software resets; code loads it high, then rate 10 drives it low on the first clock.
// (R23) Two interface-mode bits select among the three register modes.
// (R24) Drive control reset takes precedence over the self-clearing rate reset.
// (R25) Control writes update only rate bits, plus no-precomp in third mode.
`include "fhr_defines.svh"
`default_nettype none

module fhr_regs
    import fhr_pkg::*;
(
    input wire logic pclk, // Bus clock, 40 MHz
    input wire logic presetn, // Hardware reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    output logic [31:0] prdata, // APB read data
    input wire logic disk_change_cable, // Raw media change pin
    input wire fhr_core_stat_t core_stat, // Status from the core
    output fhr_core_ctl_t core_ctl, // Controls toward the core
    output fhr_drive_out_t drive_out // Cable side outputs
);

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------

    // Density level for a rate code
    function automatic logic density_of(input logic [1:0] rate);
        density_of = (rate == 2'b11) || (rate == 2'b00); // R08
    endfunction : density_of

    // MFM data rate in Kbps, halved for FM
    function automatic logic [11:0] kbps_of(input logic [1:0] rate, input logic [1:0] drt, input logic mfm);
        logic [11:0] k;
        k = `FHR_KBPS_250;
        case (rate) // R08
            2'b11: k = `FHR_KBPS_1M;
            2'b00: k = `FHR_KBPS_500;
            2'b10: k = `FHR_KBPS_250;
            2'b01:
            begin
                case (drt)
                    2'b00: k = `FHR_KBPS_300;
                    2'b01: k = `FHR_KBPS_500;
                    2'b10: k = `FHR_KBPS_2M;
                    default: k = `FHR_KBPS_300;
                endcase
            end
            default: k = `FHR_KBPS_250;
        endcase
        kbps_of = mfm ? k : {1'b0, k[11:1]};
    endfunction : kbps_of

    // Precompensation delay in 10 ps units
    // Code 7 is the default setting: one step at 1 Mbps and above,
    // a fixed 125 ns below that
    function automatic logic [15:0] precomp_of(input logic [2:0] code, input logic [11:0] kbps);
        logic [15:0] step;
        logic [15:0] n;
        step = (kbps == `FHR_KBPS_2M) ? `FHR_PRE_STEP_HI : `FHR_PRE_STEP_LO; // R05
        n = {13'h0000, code};
        if (code != `FHR_PRECOMP_DEFAULT)
        begin
            precomp_of = 16'(step * n);
        end
        else if (kbps >= `FHR_KBPS_1M)
        begin
            precomp_of = step;
        end
        else
        begin
            precomp_of = `FHR_PRE_DEF_LO;
        end
    endfunction : precomp_of

    // ----------------------------------------
    // State
    // ----------------------------------------
    fhr_state_t q;
    fhr_state_t d;
    logic setup;
    logic done;
    logic [9:0] idx;
    logic aligned;
    logic hit;
    logic [7:0] rd_byte;
    logic media;
    logic [1:0] sel_pair;
    logic wr_data;
    logic wr_rsel;

    // Decode of the current APB request
    // The first access cycle captures read data, so status sampled
    // there already shows a data transfer that completed earlier;
    // the completing cycle commits writes
    always_comb
    begin
        setup = psel && penable && !q.pready;
        done = psel && penable && q.pready;
        idx = paddr[11:2];
        aligned = (paddr[1:0] == 2'b00);
        hit = aligned && ((idx == `FHR_IDX_TAPE) || (idx == `FHR_IDX_RATE) || (idx == `FHR_IDX_DATA)
            || (idx == `FHR_IDX_INPUT) || (idx == `FHR_IDX_DOC) || (idx == `FHR_IDX_IFM)
            || (idx == `FHR_IDX_DTC) || (idx == `FHR_IDX_MISC));
        wr_data = done && pwrite && hit;
        wr_rsel = wr_data && (idx == `FHR_IDX_RATE);
    end

    // Read data selection
    always_comb
    begin
        media = q.force_en ? q.force_val : !q.dsk_s2; // R19
        case (q.drv_ctl_sel) // R02
            2'b00: sel_pair = q.dtype_cfg[1:0];
            2'b01: sel_pair = q.dtype_cfg[3:2];
            2'b10: sel_pair = q.dtype_cfg[5:4];
            default: sel_pair = q.dtype_cfg[7:6];
        endcase
        rd_byte = 8'h00;
        case (idx)
            `FHR_IDX_TAPE:
            begin
                rd_byte = {6'h00, q.tape_unit_select}; // R01
                if (q.tape_enhanced)
                begin
                    rd_byte[5:4] = sel_pair; // R02
                end
            end
            // Handshake status, reserved bits stay low
            `FHR_IDX_RATE:
            begin
                rd_byte[7] = core_stat.host_transfer_allowed; // R13
                rd_byte[6] = core_stat.transfer_way; // R13
                rd_byte[4] = core_stat.cmd_busy; // R12
                rd_byte[0] = core_stat.drive_seeking; // R10 R11
            end
            `FHR_IDX_DATA: rd_byte = core_stat.rd_byte;
            // Input register layout depends on the interface mode
            `FHR_IDX_INPUT:
            begin
                case (q.iface_mode) // R23
                    FHR_MODE_SECOND: rd_byte = {media, 4'hF, q.rate[1], q.rate[0], !q.drv.density_output}; // R20
                    FHR_MODE_THIRD: rd_byte = {media, 3'b000, q.drv_ctl_engine, q.no_precomp_flag, q.rate}; // R21
                    default: rd_byte = {media, 7'h00}; // R19
                endcase
            end
            `FHR_IDX_DOC: rd_byte = {4'h0, q.drv_ctl_engine, q.drv_ctl_run, q.drv_ctl_sel};
            `FHR_IDX_IFM: rd_byte = {4'h0, q.iface_mode, 2'b00};
            `FHR_IDX_DTC: rd_byte = q.dtype_cfg;
            `FHR_IDX_MISC: rd_byte = {1'b0, q.force_val, q.force_en, q.tape_enhanced,
                q.drive_type_setting, q.drive_rate_setting};
            default: rd_byte = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    // Register map, byte address = 4 x index:
    //   tape and drive type, rate select write / status read,
    //   data byte port, rate control write / input register read.
    // Local configuration words hold what a configuration space
    // holds elsewhere: drive control, interface mode, drive type
    // pairs and miscellaneous settings (drive rate table, drive
    // type table, enhanced tape mode, forced media change).
    // Unmapped or misaligned addresses answer with an error; unmapped
    // ones read back zero, misaligned ones read the register of their
    // index; writes to them are dropped.
    always_comb
    begin
        d = q;
        // Media change pin synchroniser
        // Two stages before anything reads the pin
        d.dsk_s1 = disk_change_cable;
        d.dsk_s2 = q.dsk_s1;
        // One-cycle pulses default low
        d.ctl.data_wr = 1'b0;
        d.ctl.data_rd = 1'b0;
        d.ctl.fifo_flush = 1'b0;
        d.ctl.cmd_abort = 1'b0;
        // APB: one wait state, data captured in the first access cycle
        d.pready = setup;
        // Error flag stands only alongside ready
        d.pslverr = setup && !hit;
        if (setup)
        begin
            d.prdata = {24'h00_0000, pwrite ? 8'h00 : rd_byte};
        end
        // Register writes take effect at the completing edge
        if (wr_data)
        begin
            case (idx)
                `FHR_IDX_TAPE: d.tape_unit_select = pwdata[1:0]; // R01
                `FHR_IDX_RATE:
                begin
                    d.rate = pwdata[1:0]; // R04
                    d.precomp = pwdata[4:2]; // R05
                    if (pwdata[`FHR_RSEL_PWR_BIT])
                    begin
                        d.ctl.low_power = 1'b1; // R06
                    end
                end
                `FHR_IDX_DATA:
                begin
                    d.ctl.data_wr = 1'b1;
                    d.ctl.data_wr_byte = pwdata[7:0];
                end
                // Rate control: reserved bits ignored, no-precomp only in the third mode
                `FHR_IDX_INPUT:
                begin
                    d.rate = pwdata[1:0]; // R04 R25
                    if (q.iface_mode == FHR_MODE_THIRD)
                    begin
                        d.no_precomp_flag = pwdata[2]; // R25
                    end
                end
                `FHR_IDX_DOC:
                begin
                    // Drive control: select, run (0 holds reset), engine enable
                    d.drv_ctl_sel = pwdata[1:0];
                    d.drv_ctl_run = pwdata[2];
                    d.drv_ctl_engine = pwdata[3];
                end
                `FHR_IDX_IFM: d.iface_mode = fhr_mode_t'(pwdata[3:2]); // R23
                `FHR_IDX_DTC: d.dtype_cfg = pwdata[7:0];
                `FHR_IDX_MISC:
                begin
                    d.drive_rate_setting = pwdata[1:0];
                    d.drive_type_setting = pwdata[3:2];
                    d.tape_enhanced = pwdata[4];
                    d.force_en = pwdata[5];
                    d.force_val = pwdata[6];
                end
                default: d.tape_unit_select = q.tape_unit_select;
            endcase
        end
        // Reads with side effects
        if (done && !pwrite && hit)
        begin
            if (idx == `FHR_IDX_DATA)
            begin
                d.ctl.data_rd = 1'b1;
            end
        end
        // Data port or status access ends low power
        // Software reset ends it as well, further down
        if (done && hit && ((idx == `FHR_IDX_DATA) || ((idx == `FHR_IDX_RATE) && !pwrite)))
        begin
            d.ctl.low_power = 1'b0; // R06
        end
        // Self-clearing reset stretched to the minimum reset width
        // One write gives several reset cycles, so the core sees the
        // minimum width without a second host write
        if (wr_rsel && pwdata[`FHR_RSEL_RST_BIT])
        begin
            d.swrst_cnt = 3'(`FHR_SWRST_CYC); // R07
        end
        else if (q.swrst_cnt != 3'h0)
        begin
            d.swrst_cnt = q.swrst_cnt - 3'h1; // R07
        end
        // Drive control reset holds the core on its own, so it wins
        // over the stretch counter running out
        d.ctl.core_reset = !d.drv_ctl_run || (d.swrst_cnt != 3'h0); // R24
        // FIFO enable, bypass and flush
        // Flush is one pulse on the rise of execution, so stale bytes
        // of a cut command never reach the host
        if (core_stat.fifo_cfg_set)
        begin
            d.fifo_en = 1'b1; // R15
        end
        d.exec_seen = core_stat.exec_phase;
        if (core_stat.exec_phase && !q.exec_seen)
        begin
            d.ctl.fifo_flush = 1'b1; // R16
        end
        if (!core_stat.exec_phase)
        begin
            d.ctl.zero_fill = 1'b0;
        end
        // Overrun or underrun ends the command
        if (core_stat.xfer_error && core_stat.exec_phase)
        begin
            d.ctl.cmd_abort = 1'b1; // R17
            d.ctl.zero_fill = core_stat.disk_write; // R17
        end
        // Software reset clears core-facing state only
        if (q.ctl.core_reset)
        begin
            d.fifo_en = 1'b0; // R15
            d.ctl.low_power = 1'b0; // R06
            d.ctl.zero_fill = 1'b0;
            d.ctl.cmd_abort = 1'b0;
            d.ctl.fifo_flush = 1'b0;
        end
        d.ctl.fifo_active = d.fifo_en && core_stat.exec_phase; // R16
        // Mirrors of drive control toward the core
        d.ctl.transfer_engine_enable = d.drv_ctl_engine;
        d.ctl.drive_select = d.drv_ctl_sel;
        // Cable side outputs follow the active rate
        // Software resets never touch the rate, so density keeps its level
        // through them
        d.drv.density_output = density_of(d.rate); // R08 R22
        case (d.drive_type_setting) // R09
            2'b00: d.drv.drive_density_pins = {d.rate[0], d.drv.density_output};
            2'b10: d.drv.drive_density_pins = {d.rate[0], d.rate[1]};
            2'b01: d.drv.drive_density_pins = {d.rate[0], !d.drv.density_output};
            default: d.drv.drive_density_pins = {d.rate[1], d.rate[0]};
        endcase
        d.drv.precomp_code = d.precomp;
        d.drv.rate_kbps = kbps_of(d.rate, d.drive_rate_setting, core_stat.mfm); // R08
        d.drv.precomp_delay = precomp_of(d.precomp, kbps_of(d.rate, d.drive_rate_setting, 1'b1)); // R05
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Hardware reset: 250 Kbps, density high, core held in reset
    // until drive control releases it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.rate <= `FHR_RATE_RESET; // R03
            q.precomp <= `FHR_PRECOMP_RESET; // R03
            q.ctl.core_reset <= 1'b1;
            q.drv.density_output <= 1'b1; // R22
            q.drv.drive_density_pins <= 2'b01;
            q.drv.rate_kbps <= `FHR_KBPS_250;
        end
        else
        begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Outputs straight from the state register
    // ----------------------------------------
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign prdata = q.prdata;
    assign core_ctl = q.ctl;
    assign drive_out = q.drv;

endmodule : fhr_regs

`default_nettype wire

// *** tb/fhr_regs_sva.sv ***
`default_nettype none

module fhr_regs_sva
    import fhr_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Access
    input wire logic pwrite, // Direction
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic [31:0] prdata, // Read data
    input wire logic disk_change_cable, // Cable pin
    input wire fhr_core_stat_t core_stat, // Core status
    input wire fhr_core_ctl_t core_ctl, // Core controls
    input wire fhr_drive_out_t drive_out // Cable outputs
);
    // ----------------------------------------
    // Bus cycle checks
    // ----------------------------------------
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic done;
    // Completing access
    assign done = psel && penable && pready;
    a_ready_one: assert property (pready |=> !pready) else $error("ready held");
    a_wait_state: assert property (psel && penable && !pready |=> pready) else $error("no ready");
    a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
    a_msr_resv: assert property (done && !pwrite && paddr == 12'hFD0 |-> (prdata & 32'hFFFF_FF2E) == 32'h0000_0000)
        else $error("status reserved bits");
    // ----------------------------------------
    // Core side checks
    // ----------------------------------------
    a_data_wr: assert property (done && pwrite && paddr == 12'hFD4 |=> core_ctl.data_wr
        && core_ctl.data_wr_byte == $past(pwdata[7:0])) else $error("data byte lost");
    a_lp_exit: assert property (done && paddr == 12'hFD4 |=> !core_ctl.low_power) else $error("low power kept");
    a_swrst_len: assert property (done && pwrite && paddr == 12'hFD0 && pwdata[7] |=> core_ctl.core_reset [*4])
        else $error("soft reset short");
    a_flush_exec: assert property ($rose(core_stat.exec_phase) |-> ##[1:2] core_ctl.fifo_flush)
        else $error("no flush");
    a_abort_err: assert property (core_stat.xfer_error && core_stat.exec_phase |-> ##[1:2] core_ctl.cmd_abort)
        else $error("no abort");
endmodule : fhr_regs_sva

bind fhr_regs fhr_regs_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .disk_change_cable, .core_stat, .core_ctl, .drive_out);

`default_nettype wire

// *** tb/fhr_core_model.sv ***
`default_nettype none

module fhr_core_model
    import fhr_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire fhr_core_ctl_t ctl, // From slice
    input wire logic exec, // Execution phase
    input wire logic xerr, // Overrun pulse
    input wire logic dir, // Host must read
    output fhr_core_stat_t stat // To slice
);
    logic [7:0] byte_q;
    // Echo last written byte
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            byte_q <= 8'h00;
        else if (ctl.data_wr)
            byte_q <= ctl.data_wr_byte;
    end
    // Status levels
    always_comb
    begin
        stat = '0;
        stat.host_transfer_allowed = !ctl.core_reset;
        stat.transfer_way = dir;
        stat.cmd_busy = exec;
        stat.drive_seeking = exec;
        stat.exec_phase = exec;
        stat.xfer_error = xerr;
        stat.disk_write = 1'b1;
        stat.mfm = 1'b1;
        stat.rd_byte = byte_q;
    end
endmodule : fhr_core_model

`default_nettype wire

// *** tb/tb_top.sv ***
`include "fhr_defines.svh"
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected at %0t got %h exp %h", $time, g, e); end end

module tb_top
    import fhr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cable = 0, exec = 0, xerr = 0, dir = 0, er;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr;
    fhr_core_stat_t stat;
    fhr_core_ctl_t ctl;
    fhr_drive_out_t dout;
    int bad_count = 0, checked = 0;
    logic [11:0] kbps [4] = '{12'd500, 12'd300, 12'd250, 12'd1000};
    logic dens [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    localparam logic [11:0] A_DOC = {`FHR_IDX_DOC, 2'b00}, A_IFM = {`FHR_IDX_IFM, 2'b00};
    localparam logic [11:0] A_TAP = {`FHR_IDX_TAPE, 2'b00}, A_RSL = {`FHR_IDX_RATE, 2'b00};
    localparam logic [11:0] A_DAT = {`FHR_IDX_DATA, 2'b00}, A_INP = {`FHR_IDX_INPUT, 2'b00};
    localparam logic [11:0] A_DTC = {`FHR_IDX_DTC, 2'b00}, A_MSC = {`FHR_IDX_MISC, 2'b00};

    always #12.5 pclk = ~pclk;

    fhr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .disk_change_cable(cable), .core_stat(stat), .core_ctl(ctl), .drive_out(dout));
    fhr_core_model u_core (.pclk(pclk), .presetn(presetn), .ctl(ctl), .exec(exec), .xerr(xerr),
        .dir(dir), .stat(stat));

    // ----------------------------------------
    // Verdict and bus tasks
    // ----------------------------------------
    task conclude;
        if (bad_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            bad_count++;
            conclude();
        end
    endtask : apb

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK(dout.rate_kbps, `FHR_KBPS_250)
        apb(1, A_DOC, 32'h0000_000C);
        apb(0, A_INP, 0);
        `CHK(rd, 32'h0000_0080)
        apb(1, A_TAP, 32'h0000_00FF);
        apb(0, A_TAP, 0);
        `CHK(rd, 32'h0000_0003)
        apb(1, A_DTC, 32'h0000_00E4);
        apb(1, A_MSC, 32'h0000_0010);
        apb(1, A_DOC, 32'h0000_000E);
        apb(0, A_TAP, 0);
        `CHK(rd, 32'h0000_0023)
        `CHK(ctl.drive_select, 2'h2)
        apb(1, A_IFM, 32'h0000_0004);
        for (int i = 0; i < 4; i++)
        begin
            apb(1, A_INP, i);
            repeat (2) @(posedge pclk);
            `CHK(dout.rate_kbps, kbps[i])
            `CHK(dout.drive_density_pins, {i[0], dens[i]})
            apb(0, A_INP, 0);
            `CHK(rd[7:0], {5'h1F, i[1:0], ~dens[i]})
        end
        apb(1, A_RSL, 32'h0000_0003);
        repeat (2) @(posedge pclk);
        `CHK(dout.rate_kbps, `FHR_KBPS_1M)
        apb(1, A_INP, 32'h0000_0006);
        repeat (2) @(posedge pclk);
        `CHK(dout.rate_kbps, `FHR_KBPS_250)
        apb(1, A_IFM, 32'h0000_0008);
        apb(1, A_INP, 32'h0000_00FD);
        apb(0, A_INP, 0);
        `CHK(rd, 32'h0000_008D)
        apb(1, A_RSL, 32'h0000_0083);
        repeat (6) @(posedge pclk);
        `CHK(ctl.core_reset, 1'b0)
        `CHK(dout.rate_kbps, `FHR_KBPS_1M)
        `CHK(dout.density_output, 1'b1)
        apb(1, A_RSL, 32'h0000_000F);
        repeat (2) @(posedge pclk);
        `CHK(dout.precomp_delay, 16'(3 * `FHR_PRE_STEP_LO))
        apb(1, A_RSL, 32'h0000_0043);
        repeat (2) @(posedge pclk);
        `CHK(ctl.low_power, 1'b1)
        exec <= 1'b1;
        dir <= 1'b1;
        apb(0, A_RSL, 0);
        `CHK(rd, 32'h0000_00D1)
        repeat (2) @(posedge pclk);
        `CHK(ctl.low_power, 1'b0)
        xerr <= 1'b1;
        @(posedge pclk);
        xerr <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK(ctl.zero_fill, 1'b1)
        exec <= 1'b0;
        dir <= 1'b0;
        apb(1, A_DOC, 32'h0000_0008);
        apb(1, A_RSL, 32'h0000_0082);
        repeat (6) @(posedge pclk);
        `CHK(ctl.core_reset, 1'b1)
        apb(1, A_DOC, 32'h0000_000C);
        apb(0, A_RSL, 0);
        `CHK(rd[7:6], 2'b10)
        apb(1, A_DAT, 32'h0000_005A);
        apb(0, A_DAT, 0);
        `CHK(rd, 32'h0000_005A)
        apb(0, 12'h010, 0);
        `CHK({er, rd}, {1'b1, 32'h0000_0000})
        conclude();
    end
endmodule : tb_top

`default_nettype wire
